/* core/prca_top.sv */
`timescale 1ns/1ns
`include "prca_params.svh"

// Functional notes
// - One shared 16-bit time base feeds five capture/compare modules.
// - Time base clock picks one of six sources, including three divided ones.
// - Each module runs capture, timer, fast output, 8/16-bit PWM or frequency.
// - Module 4 can also serve as a watchdog.
// - After reset module 4 is a watchdog, already enabled.
// - Module pins and the count input go out through the pin crossbar.
// - Time base may count the external oscillator while the core runs internally.
// - Debug halt freezes the time base and prescalers; capture on pin edges still runs.
module prca_top #(
    parameter int NMOD = `PRCA_NMOD
) (
    // Clock and reset
    input  wire logic                            clock,
    input  wire logic                            rst_b,
    // Time base control
    input  wire logic                            run,
    input  wire prca_pkg::prca_src_t             src_sel,
    input  wire logic                            debug_halt,
    input  wire logic                            ovf_clear,
    // Count sources
    input  wire logic                            timer0_ovf,
    input  wire logic                            ext_count_input,
    input  wire logic                            ext_osc,
    // Time base status
    output logic [`PRCA_TB_W-1:0]                count,
    output logic                                 ovf_flag,
    // Capture/compare modules
    input  wire prca_pkg::prca_mode_t            mode       [NMOD],
    input  wire logic [`PRCA_TB_W-1:0]           compare    [NMOD],
    input  wire logic [NMOD-1:0]                 flag_clear,
    input  wire logic [NMOD-1:0]                 module_in,
    output logic [NMOD-1:0]                      module_out,
    output logic [NMOD-1:0]                      module_oe,
    output logic [`PRCA_TB_W-1:0]                capture    [NMOD],
    output logic [NMOD-1:0]                      match_flag,
    // Watchdog on module 4
    input  wire logic                            wdt_disable,
    input  wire logic                            wdt_kick,
    input  wire logic [7:0]                      wdt_offset,
    output logic                                 wdt_enabled,
    output logic                                 wdt_reset
);

    logic [3:0]            div12_r,  div12_nxt;
    logic [1:0]            div4_r,   div4_nxt;
    logic [2:0]            div8_r,   div8_nxt;
    logic                  osc_q_r,  osc_q_nxt;
    logic                  cin_q_r,  cin_q_nxt;
    logic [`PRCA_TB_W-1:0] count_r,  count_nxt;
    logic                  ovf_r,    ovf_nxt;
    logic                  tick;
    logic                  active;
    logic                  osc_rise;
    logic [NMOD-1:0]       en_vec;
    logic [NMOD-1:0]       fire_vec;

    prca_tb_if tb_bus ();

    // Prescalers stop under debug halt so the array stays in step.
    assign active   = run && !debug_halt;
    assign osc_rise = ext_osc && !osc_q_r;

    // ------------------------------------------------------------------
    // Prescalers and edge detectors
    // ------------------------------------------------------------------
    always_comb begin
        div12_nxt = div12_r;
        div4_nxt  = div4_r;
        div8_nxt  = div8_r;
        osc_q_nxt = ext_osc;
        cin_q_nxt = ext_count_input;
        if (active) begin
            div12_nxt = (div12_r == 4'(`PRCA_DIV_SLOW - 1)) ? 4'h0 : 4'(div12_r + 4'h1);
            div4_nxt  = (div4_r == 2'(`PRCA_DIV_FAST - 1)) ? 2'h0 : 2'(div4_r + 2'h1);
            // Oscillator edges are counted here, not used as a clock.
            if (osc_rise) begin
                div8_nxt = (div8_r == 3'(`PRCA_DIV_OSC - 1)) ? 3'h0 : 3'(div8_r + 3'h1);
            end
        end
    end

    // Source select; every source becomes a one-cycle tick.
    always_comb begin
        case (src_sel)
            prca_pkg::SRC_SYS_DIV12:    tick = (div12_r == 4'(`PRCA_DIV_SLOW - 1));
            prca_pkg::SRC_SYS_DIV4:     tick = (div4_r == 2'(`PRCA_DIV_FAST - 1));
            prca_pkg::SRC_TIMER0_OVF:   tick = timer0_ovf;
            prca_pkg::SRC_EXT_COUNT:    tick = ext_count_input && !cin_q_r;
            prca_pkg::SRC_SYS:          tick = 1'b1;
            prca_pkg::SRC_EXT_OSC_DIV8: tick = osc_rise
                                               && (div8_r == 3'(`PRCA_DIV_OSC - 1));
            default:                    tick = 1'b0;
        endcase
        tick = tick && active;
    end

    // ------------------------------------------------------------------
    // Time base and overflow flag
    // ------------------------------------------------------------------
    always_comb begin
        count_nxt = count_r;
        if (tick) begin
            count_nxt = `PRCA_TB_W'(count_r + 1'b1);
        end
        // A wrap in the clearing cycle is kept.
        ovf_nxt = (ovf_r && !ovf_clear) || (tick && (&count_r));
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div12_r <= 4'h0;
            div4_r  <= 2'h0;
            div8_r  <= 3'h0;
            osc_q_r <= 1'b0;
            cin_q_r <= 1'b0;
            count_r <= `PRCA_COUNT_RST;
            ovf_r   <= 1'b0;
        end else begin
            div12_r <= div12_nxt;
            div4_r  <= div4_nxt;
            div8_r  <= div8_nxt;
            osc_q_r <= osc_q_nxt;
            cin_q_r <= cin_q_nxt;
            count_r <= count_nxt;
            ovf_r   <= ovf_nxt;
        end
    end

    assign tb_bus.count = count_r;
    assign tb_bus.tick  = tick;
    assign count        = count_r;
    assign ovf_flag     = ovf_r;

    // ------------------------------------------------------------------
    // Capture/compare modules on the shared time base
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NMOD; i++) begin : g_ccm
        prca_ccm #(
            .IS_WDT (i == `PRCA_WDT_INDEX)
        ) u_ccm (
            .clock       (clock),
            .rst_b       (rst_b),
            .tb          (tb_bus.sink),
            .mode        (mode[i]),
            .compare     (compare[i]),
            .flag_clear  (flag_clear[i]),
            .wdt_disable (wdt_disable),
            .wdt_kick    (wdt_kick),
            .wdt_offset  (wdt_offset),
            .pin_in      (module_in[i]),
            .pin_out     (module_out[i]),
            .pin_oe      (module_oe[i]),
            .capture     (capture[i]),
            .flag        (match_flag[i]),
            .wdt_enabled (en_vec[i]),
            .wdt_fire    (fire_vec[i])
        );
    end

    // Only module 4 has a live watchdog; the others tie theirs low.
    assign wdt_enabled = en_vec[`PRCA_WDT_INDEX];
    assign wdt_reset   = fire_vec[`PRCA_WDT_INDEX];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_count_step: assert property (@(posedge clock) disable iff (!rst_b)
        tick |=> count == `PRCA_TB_W'($past(count) + 1'b1))
        else $error("time base did not step by one");

    chk_halt_freeze: assert property (@(posedge clock) disable iff (!rst_b)
        debug_halt |=> count == $past(count))
        else $error("time base moved while halted");

    chk_ovf_set: assert property (@(posedge clock) disable iff (!rst_b)
        (tick && count == 16'hFFFF) |=> ovf_flag && count == 16'h0000)
        else $error("wrap did not set the overflow flag");

    chk_ovf_sticky: assert property (@(posedge clock) disable iff (!rst_b)
        (ovf_flag && !ovf_clear) |=> ovf_flag)
        else $error("overflow flag lost without a clear");

    chk_div12_gap: assert property (@(posedge clock) disable iff (!rst_b)
        (tick && src_sel == prca_pkg::SRC_SYS_DIV12)
        |=> (!tick || src_sel != prca_pkg::SRC_SYS_DIV12) [*8])
        else $error("divide by twelve ticked too soon");

    chk_div4_gap: assert property (@(posedge clock) disable iff (!rst_b)
        (tick && src_sel == prca_pkg::SRC_SYS_DIV4)
        |=> (!tick || src_sel != prca_pkg::SRC_SYS_DIV4) [*3])
        else $error("divide by four ticked too soon");

    chk_sys_tick: assert property (@(posedge clock) disable iff (!rst_b)
        (src_sel == prca_pkg::SRC_SYS && run && !debug_halt) |-> tick)
        else $error("system clock source missed a cycle");

    chk_count_edge: assert property (@(posedge clock) disable iff (!rst_b)
        (tick && src_sel == prca_pkg::SRC_EXT_COUNT)
        |-> ext_count_input && !$past(ext_count_input))
        else $error("count input ticked without a rising edge");

    chk_wdt_boot: assert property (@(posedge clock) disable iff (!rst_b)
        !$past(rst_b) |-> wdt_enabled)
        else $error("watchdog not armed after reset");

    chk_wdt_cause: assert property (@(posedge clock) disable iff (!rst_b)
        wdt_reset |-> $past(wdt_enabled) && $past(tick))
        else $error("watchdog fired while disabled");

    cov_overflow: cover property (@(posedge clock) disable iff (!rst_b) $rose(ovf_flag));
    cov_wdt_fire: cover property (@(posedge clock) disable iff (!rst_b) wdt_reset);
    cov_capture:  cover property (@(posedge clock) disable iff (!rst_b) $rose(match_flag[0]));

endmodule : prca_top

/* core/prca_params.svh */
`ifndef PRCA_PARAMS_SVH
`define PRCA_PARAMS_SVH

// ----------------------------------------------------------------------
// Time base and module counts
// ----------------------------------------------------------------------
`define PRCA_TB_W        16
`define PRCA_NMOD        5
`define PRCA_WDT_INDEX   4

// ----------------------------------------------------------------------
// Prescaler divide ratios, in system clock cycles or oscillator edges
// ----------------------------------------------------------------------
`define PRCA_DIV_SLOW    12
`define PRCA_DIV_FAST    4
`define PRCA_DIV_OSC     8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PRCA_COUNT_RST   16'h0000
`define PRCA_WDT_LIM_RST 8'hFF
`define PRCA_WDT_EN_RST  1'b1

`endif

/* core/prca_pkg.sv */
package prca_pkg;

    // ------------------------------------------------------------------
    // Time base clock sources
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_SYS_DIV12,
        SRC_SYS_DIV4,
        SRC_TIMER0_OVF,
        SRC_EXT_COUNT,
        SRC_SYS,
        SRC_EXT_OSC_DIV8
    } prca_src_t;

    // ------------------------------------------------------------------
    // Capture/compare module modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF,
        MODE_CAPTURE,
        MODE_SW_TIMER,
        MODE_HS_OUTPUT,
        MODE_PWM8,
        MODE_PWM16,
        MODE_FREQ_OUT
    } prca_mode_t;

endpackage : prca_pkg

/* core/prca_tb_if.sv */
`timescale 1ns/1ns
`include "prca_params.svh"

// Shared time base as seen by every capture/compare module.
interface prca_tb_if;
    logic [`PRCA_TB_W-1:0] count;
    logic                  tick;

    modport source (output count, output tick);
    modport sink   (input count, input tick);
endinterface : prca_tb_if

/* core/prca_ccm.sv */
`timescale 1ns/1ns
`include "prca_params.svh"

module prca_ccm #(
    parameter bit IS_WDT = 1'b0
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // Shared time base
    prca_tb_if.sink                    tb,
    // Configuration
    input  wire prca_pkg::prca_mode_t  mode,
    input  wire logic [`PRCA_TB_W-1:0] compare,
    input  wire logic                  flag_clear,
    // Watchdog control, used only when IS_WDT is set
    input  wire logic                  wdt_disable,
    input  wire logic                  wdt_kick,
    input  wire logic [7:0]            wdt_offset,
    // Pin side
    input  wire logic                  pin_in,
    output logic                       pin_out,
    output logic                       pin_oe,
    // Status
    output logic [`PRCA_TB_W-1:0]      capture,
    output logic                       flag,
    output logic                       wdt_enabled,
    output logic                       wdt_fire
);

    logic                  out_r,   out_nxt;
    logic                  flag_r,  flag_nxt;
    logic                  in_q_r,  in_q_nxt;
    logic [`PRCA_TB_W-1:0] cap_r,   cap_nxt;
    logic [7:0]            freq_r,  freq_nxt;
    logic                  wen_r,   wen_nxt;
    logic [7:0]            wlim_r,  wlim_nxt;
    logic                  fire_r,  fire_nxt;
    logic                  wdt_on;
    logic                  set_ev;

    assign wdt_on = IS_WDT && wen_r;

    // --------------------------------------------------------------
    // Mode behaviour; while the watchdog owns the module the ordinary
    // mode is parked so a stray compare cannot disturb the pin.
    // --------------------------------------------------------------
    always_comb begin
        out_nxt  = out_r;
        cap_nxt  = cap_r;
        freq_nxt = freq_r;
        set_ev   = 1'b0;
        in_q_nxt = pin_in;
        if (!wdt_on) begin
            case (mode)
                prca_pkg::MODE_CAPTURE: begin
                    if (pin_in && !in_q_r) begin
                        cap_nxt = tb.count;
                        set_ev  = 1'b1;
                    end
                end
                prca_pkg::MODE_SW_TIMER: begin
                    set_ev = tb.tick && (tb.count == compare);
                end
                prca_pkg::MODE_HS_OUTPUT: begin
                    if (tb.tick && (tb.count == compare)) begin
                        set_ev  = 1'b1;
                        out_nxt = !out_r;
                    end
                end
                prca_pkg::MODE_PWM8: begin
                    out_nxt = (tb.count[7:0] >= compare[7:0]);
                end
                prca_pkg::MODE_PWM16: begin
                    out_nxt = (tb.count >= compare);
                end
                prca_pkg::MODE_FREQ_OUT: begin
                    // Low byte chases a moving target, high byte is the step.
                    if (tb.tick && (tb.count[7:0] == freq_r)) begin
                        out_nxt  = !out_r;
                        freq_nxt = 8'(freq_r + compare[15:8]);
                    end
                end
                default: begin
                    out_nxt = 1'b0;
                end
            endcase
        end
        if (mode != prca_pkg::MODE_FREQ_OUT) begin
            freq_nxt = compare[7:0];
        end
        // An event in the clearing cycle wins over the clear.
        flag_nxt = (flag_r && !flag_clear) || set_ev;
    end

    // --------------------------------------------------------------
    // Watchdog: fires when the high byte reaches the limit; a kick
    // moves the limit ahead of the current count.
    // --------------------------------------------------------------
    always_comb begin
        wen_nxt  = wen_r && !wdt_disable;
        wlim_nxt = wlim_r;
        fire_nxt = 1'b0;
        if (wdt_on) begin
            if (wdt_kick) begin
                wlim_nxt = 8'(tb.count[15:8] + wdt_offset);
            end else if (tb.tick && (tb.count[15:8] == wlim_r)) begin
                fire_nxt = 1'b1;
            end
        end
    end

    // Register stage; the watchdog comes up armed with no software help.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            out_r  <= 1'b0;
            flag_r <= 1'b0;
            in_q_r <= 1'b0;
            cap_r  <= `PRCA_COUNT_RST;
            freq_r <= 8'h00;
            wen_r  <= `PRCA_WDT_EN_RST;
            wlim_r <= `PRCA_WDT_LIM_RST;
            fire_r <= 1'b0;
        end else begin
            out_r  <= out_nxt;
            flag_r <= flag_nxt;
            in_q_r <= in_q_nxt;
            cap_r  <= cap_nxt;
            freq_r <= freq_nxt;
            wen_r  <= wen_nxt;
            wlim_r <= wlim_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign pin_out     = out_r;
    // The crossbar takes the pin only for the driving modes.
    assign pin_oe      = !wdt_on && ((mode == prca_pkg::MODE_HS_OUTPUT)
                         || (mode == prca_pkg::MODE_PWM8)
                         || (mode == prca_pkg::MODE_PWM16)
                         || (mode == prca_pkg::MODE_FREQ_OUT));
    assign capture     = cap_r;
    assign flag        = flag_r;
    assign wdt_enabled = wdt_on;
    assign wdt_fire    = fire_r;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    chk_capture_load: assert property (@(posedge clock) disable iff (!rst_b)
        (!wdt_on && mode == prca_pkg::MODE_CAPTURE && pin_in && !in_q_r)
        |=> (capture == $past(tb.count)) && flag)
        else $error("capture did not load the time base");

    chk_drive_oe: assert property (@(posedge clock) disable iff (!rst_b)
        (!wdt_on && mode == prca_pkg::MODE_CAPTURE) |-> !pin_oe)
        else $error("pin driven in capture mode");

endmodule : prca_ccm

/* test/prca_pins_model.sv */
`timescale 1ns/1ns

// Far side of the block: the count input, the oscillator and the module pins.
module prca_pins_model (
    // Clock
    input  wire logic       clock,
    // Pins driven by the block
    input  wire logic [4:0] module_out,
    input  wire logic [4:0] module_oe,
    // Lines driven towards the block
    output logic            timer0_ovf,
    output logic            ext_count_input,
    output logic            ext_osc,
    output logic [4:0]      module_in
);
    logic [4:0] drv;

    // --------------------------------------------------------------
    // Pin resolution
    // --------------------------------------------------------------
    // A pin that the block drives reads back its own value, else ours.
    assign module_in = (module_out & module_oe) | (drv & ~module_oe);

    // Idle lines stand still between bursts, so no stray counts occur.
    initial begin
        drv             = 5'h00;
        timer0_ovf      = 1'b0;
        ext_count_input = 1'b0;
        ext_osc         = 1'b0;
    end

    // --------------------------------------------------------------
    // Stimulus tasks
    // --------------------------------------------------------------
    // Each line changes just after a rising edge, like the bench.
    task automatic edge_wait(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask : edge_wait

    task automatic t0(input int n);
        repeat (n) begin
            timer0_ovf = 1'b1;
            edge_wait(1);
            timer0_ovf = 1'b0;
            edge_wait(1);
        end
    endtask : t0

    // Two cycles high and two low keep edges far enough apart to be seen.
    task automatic count_in(input int n);
        repeat (n) begin
            ext_count_input = 1'b1;
            edge_wait(2);
            ext_count_input = 1'b0;
            edge_wait(2);
        end
    endtask : count_in

    // The oscillator runs only in bursts, one core clock cycle high and one low.
    task automatic osc(input int n);
        repeat (n) begin
            ext_osc = 1'b1;
            edge_wait(1);
            ext_osc = 1'b0;
            edge_wait(1);
        end
    endtask : osc

    task automatic pin(input int i, input logic v);
        drv[i] = v;
    endtask : pin
endmodule : prca_pins_model

/* test/prca_tb_top.sv */
`timescale 1ns/1ns

module prca_tb_top;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic                 clock;
    logic                 rst_b;
    logic                 run;
    prca_pkg::prca_src_t  src_sel;
    logic                 debug_halt;
    logic                 ovf_clear;
    logic                 timer0_ovf;
    logic                 ext_count_input;
    logic                 ext_osc;
    logic [15:0]          count;
    logic                 ovf_flag;
    prca_pkg::prca_mode_t mode [5];
    logic [15:0]          compare [5];
    logic [4:0]           flag_clear;
    logic [4:0]           module_in;
    logic [4:0]           module_out;
    logic [4:0]           module_oe;
    logic [15:0]          capture [5];
    logic [4:0]           match_flag;
    logic                 wdt_disable;
    logic                 wdt_kick;
    logic [7:0]           wdt_offset;
    logic                 wdt_enabled;
    logic                 wdt_reset;
    int                   fails;
    int                   checked;
    int                   cycles;
    int                   pulses;
    logic [15:0]          c0;

    // --------------------------------------------------------------
    // Instances
    // --------------------------------------------------------------
    prca_top #(.NMOD(5)) prca_top_i (
        .clock(clock), .rst_b(rst_b), .run(run), .src_sel(src_sel),
        .debug_halt(debug_halt), .ovf_clear(ovf_clear), .timer0_ovf(timer0_ovf),
        .ext_count_input(ext_count_input), .ext_osc(ext_osc), .count(count),
        .ovf_flag(ovf_flag), .mode(mode), .compare(compare), .flag_clear(flag_clear),
        .module_in(module_in), .module_out(module_out), .module_oe(module_oe),
        .capture(capture), .match_flag(match_flag), .wdt_disable(wdt_disable),
        .wdt_kick(wdt_kick), .wdt_offset(wdt_offset), .wdt_enabled(wdt_enabled),
        .wdt_reset(wdt_reset));

    prca_pins_model prca_pins_model_i (
        .clock(clock), .module_out(module_out), .module_oe(module_oe),
        .timer0_ovf(timer0_ovf), .ext_count_input(ext_count_input),
        .ext_osc(ext_osc), .module_in(module_in));

    // --------------------------------------------------------------
    // Clock, timeout and watchdog pulse counter
    // --------------------------------------------------------------
    // Period of 100 ns; the ceiling leaves room for one full wrap of the count.
    always #50 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            end_sim();
        end
    end

    // Pulses are counted on the falling edge, where they are settled.
    always @(negedge clock) begin
        if (wdt_reset === 1'b1) pulses++;
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask : step

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Runs the time base from one source for n cycles and checks the advance.
    task automatic span(input prca_pkg::prca_src_t s, input int n, input logic [15:0] d);
        src_sel = s;
        c0 = count;
        run = 1'b1;
        step(n);
        run = 1'b0;
        check(count - c0, d);
    endtask : span

    task automatic end_sim();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        clock = 1'b0; rst_b = 1'b0; run = 1'b0; src_sel = prca_pkg::SRC_SYS;
        debug_halt = 1'b0; ovf_clear = 1'b0; flag_clear = 5'h00;
        wdt_disable = 1'b0; wdt_kick = 1'b0; wdt_offset = 8'h00;
        fails = 0; checked = 0; cycles = 0; pulses = 0;
        for (int i = 0; i < 5; i++) begin
            mode[i] = prca_pkg::MODE_OFF;
            compare[i] = 16'h0000;
        end
        step(4);
        rst_b = 1'b1;
        check(count, 16'h0000);
        check({15'h0000, wdt_enabled}, 16'h0001);
        // Sources, freezing and stopping.
        span(prca_pkg::SRC_SYS, 10, 16'h000A);
        debug_halt = 1'b1;
        span(prca_pkg::SRC_SYS, 10, 16'h0000);
        debug_halt = 1'b0;
        span(prca_pkg::SRC_SYS_DIV4, 48, 16'h000C);
        span(prca_pkg::SRC_SYS_DIV12, 48, 16'h0004);
        src_sel = prca_pkg::SRC_TIMER0_OVF;
        c0 = count;
        run = 1'b1;
        prca_pins_model_i.t0(5);
        run = 1'b0;
        check(count - c0, 16'h0005);
        src_sel = prca_pkg::SRC_EXT_COUNT;
        c0 = count;
        run = 1'b1;
        prca_pins_model_i.count_in(3);
        step(3);
        run = 1'b0;
        check(count - c0, 16'h0003);
        src_sel = prca_pkg::SRC_EXT_OSC_DIV8;
        c0 = count;
        run = 1'b1;
        prca_pins_model_i.osc(16);
        step(3);
        run = 1'b0;
        check(count - c0, 16'h0002);
        // Capture with the time base stopped, so the captured value is known.
        mode[0] = prca_pkg::MODE_CAPTURE;
        c0 = count;
        step(1);
        prca_pins_model_i.pin(0, 1'b1);
        step(2);
        check(capture[0], c0);
        check({15'h0000, match_flag[0]}, 16'h0001);
        flag_clear[0] = 1'b1;
        step(1);
        flag_clear[0] = 1'b0;
        check({15'h0000, match_flag[0]}, 16'h0000);
        // Software timer and fast output share one compare point.
        mode[1] = prca_pkg::MODE_SW_TIMER;
        mode[2] = prca_pkg::MODE_HS_OUTPUT;
        compare[1] = count + 16'h0003;
        compare[2] = count + 16'h0003;
        span(prca_pkg::SRC_SYS, 6, 16'h0006);
        step(1);
        check({15'h0000, match_flag[1]}, 16'h0001);
        check({15'h0000, module_out[2]}, 16'h0001);
        // The 8-bit modulator output follows the low byte on both sides of its level.
        mode[3] = prca_pkg::MODE_PWM8;
        compare[3] = 16'h0080;
        for (int k = 0; k < 2; k++) begin
            span(prca_pkg::SRC_SYS, 128, 16'h0080);
            step(2);
            check({15'h0000, module_out[3]}, {15'h0000, k == 0});
        end
        // Every mode once; the pin is driven in the output modes only.
        for (int m = 0; m < 7; m++) begin
            mode[3] = prca_pkg::prca_mode_t'(m);
            step(1);
            check({15'h0000, module_oe[3]}, {15'h0000, m >= 3 && m <= 6});
        end
        mode[4] = prca_pkg::MODE_HS_OUTPUT;
        step(1);
        check({15'h0000, module_oe[4]}, 16'h0000);
        // A full wrap; the watchdog left at reset fires on each tick at FFxx.
        pulses = 0;
        src_sel = prca_pkg::SRC_SYS;
        run = 1'b1;
        for (int k = 0; k < 70000 && ovf_flag !== 1'b1; k++) step(1);
        run = 1'b0;
        check(count, 16'h0000);
        check({15'h0000, ovf_flag}, 16'h0001);
        // Module 3 left in frequency mode at 1 toggled 255 times on the way up.
        check({15'h0000, module_out[3]}, 16'h0000);
        step(2);
        check(pulses[15:0], 16'h0100);
        ovf_clear = 1'b1;
        step(1);
        ovf_clear = 1'b0;
        check({15'h0000, ovf_flag}, 16'h0000);
        // A kick moves the limit two high-byte steps ahead of the count.
        wdt_offset = 8'h02;
        wdt_kick = 1'b1;
        step(1);
        wdt_kick = 1'b0;
        pulses = 0;
        span(prca_pkg::SRC_SYS, 800, 16'h0320);
        step(2);
        check(pulses[15:0], 16'h0100);
        wdt_disable = 1'b1;
        step(1);
        wdt_disable = 1'b0;
        check({15'h0000, wdt_enabled}, 16'h0000);
        check({15'h0000, module_oe[4]}, 16'h0001);
        // A second reset brings the watchdog back without software action.
        rst_b = 1'b0;
        step(2);
        rst_b = 1'b1;
        check({15'h0000, wdt_enabled}, 16'h0001);
        check(count, 16'h0000);
        end_sim();
    end
endmodule : prca_tb_top
